// *** verilog/stc_top.sv ***
`timescale 1ns/1ps

// Functional notes
// - After power-up or any reset the run lamp flashes while self-diagnostics run.
// - On a passing diagnosis the run lamp turns steady once two seconds have elapsed.
// - On a failing diagnosis the run lamp keeps flashing.
// - Holding the default button forces 9600 baud, node 247, no parity.
// - While default mode is active the status lamp flashes.
// - Software or power-on reset leaves default mode.
// - New address, baud and parity apply only after the next software reset; the host follows.
// - A reply waits a programmable delay after the request frame ends.
// - The status lamp is steadily on while any channel is over-range, open or broken.
// - Slow blink for default mode, fast blink for watchdog, steady fault masks both.
// - Downscale break on the resistance range treats a saturated input as a lead break.
// - Every relay is off after software or power-on reset.
// - Relay priority is watchdog state, then alarm, then manual control.
module stc_top #(
  parameter int unsigned DIAG_CYCLES = stc_pkg::DIAG_CYCLES,
  parameter int unsigned HOLD_CYCLES = stc_pkg::HOLD_CYCLES,
  parameter int unsigned SLOW_HALF = stc_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF = stc_pkg::FAST_HALF_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Self-test and channel status
  input wire logic diag_done_i,
  input wire logic diag_fail_i,
  input wire logic [3:0] chan_fault_i,
  input wire logic [3:0] chan_sat_i,
  input wire logic [3:0] alarm_i,
  input wire logic wd_timeout_i,
  input wire logic frame_done_i,
  // Push-button pin
  input wire logic default_comm_button_i,
  // Outputs
  output logic run_led_o,
  output logic status_led_o,
  output logic [3:0] relay_o,
  output logic [3:0] downscale_o,
  output logic tx_go_o,
  output stc_pkg::stc_cfg_t comm_cfg_o,
  output logic irq_o
);

  // ****************************************************************
  // Reset, blink sources, button synchroniser
  // ****************************************************************
  logic srst;
  logic core_rst;
  logic slow_ph;
  logic fast_ph;
  logic btn_s1;
  logic btn_s2;

  assign core_rst = reset_i | srst;

  // Slow blink for default mode and diagnostics, fast for watchdog
  stc_blink #(.HALF(SLOW_HALF)) u_slow (
    .clock_i(clock_i), .reset_i(core_rst), .ce_i(ce_i), .phase_o(slow_ph));
  stc_blink #(.HALF(FAST_HALF)) u_fast (
    .clock_i(clock_i), .reset_i(core_rst), .ce_i(ce_i), .phase_o(fast_ph));

  // Two-stage synchroniser for the button pin
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
    end else if (ce_i) begin
      btn_s1 <= default_comm_button_i;
      btn_s2 <= btn_s1;
    end
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  stc_pkg::stc_cfg_t pend;
  stc_pkg::stc_cfg_t active;
  logic [15:0] delay_val;
  stc_pkg::stc_relay_t rly;
  logic [1:0] brk;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] irq_evt;
  stc_pkg::stc_run_t run_st;
  logic dflt;
  logic [3:0] fault;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd_val;
  stc_pkg::stc_cfg_t next_pend;
  stc_pkg::stc_cfg_t next_active;
  logic [15:0] next_delay_val;
  stc_pkg::stc_relay_t next_rly;
  logic [1:0] next_brk;
  logic [3:0] next_irq_stat;
  logic [3:0] next_irq_mask;
  logic next_srst;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  assign acc = psel_i & penable_i;
  assign wr = acc & pready_o & pwrite_i;

  // Read mux and decode
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr_i)
      stc_pkg::ADDR_CTRL: rd_val = 32'h0000_0000;
      stc_pkg::ADDR_PEND: rd_val = {16'h0000, pend.node_addr, 2'h0, pend.parity, pend.baud};
      stc_pkg::ADDR_ACTIVE: rd_val = {16'h0000, comm_cfg_o.node_addr, 2'h0,
                                      comm_cfg_o.parity, comm_cfg_o.baud};
      stc_pkg::ADDR_DELAY: rd_val = {16'h0000, delay_val};
      stc_pkg::ADDR_RELAY: rd_val = {16'h0000, rly};
      stc_pkg::ADDR_BRK: rd_val = {30'h0000_0000, brk};
      stc_pkg::ADDR_IRQ_STAT: rd_val = {28'h000_0000, irq_stat};
      stc_pkg::ADDR_IRQ_MASK: rd_val = {28'h000_0000, irq_mask};
      stc_pkg::ADDR_STATUS: rd_val = {16'h0000, relay_o, fault, 4'h0, dflt, run_st, run_led_o};
      default: hit = 1'b0;
    endcase
  end

  // Next register values; hardware sets win over write-one clears
  always_comb begin
    next_pready = acc & ~pready_o;
    next_pslverr = acc & ~pready_o & ~hit;
    next_prdata = (acc & ~pready_o & ~pwrite_i) ? rd_val : prdata_o;
    next_pend = pend;
    next_delay_val = delay_val;
    next_rly = rly;
    next_brk = brk;
    next_irq_mask = irq_mask;
    next_srst = 1'b0;
    next_irq_stat = irq_stat;
    if (wr) begin
      unique case (paddr_i)
        stc_pkg::ADDR_CTRL: next_srst = pwdata_i[stc_pkg::CTRL_SRST_BIT];
        stc_pkg::ADDR_PEND: next_pend = {pwdata_i[15:8], pwdata_i[5:0]};
        stc_pkg::ADDR_DELAY: next_delay_val = pwdata_i[15:0];
        stc_pkg::ADDR_RELAY: next_rly = pwdata_i[15:0];
        stc_pkg::ADDR_BRK: next_brk = pwdata_i[1:0];
        stc_pkg::ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata_i[3:0];
        stc_pkg::ADDR_IRQ_MASK: next_irq_mask = pwdata_i[3:0];
        default: next_srst = 1'b0;
      endcase
    end
    next_irq_stat = next_irq_stat | irq_evt;
    next_active = active;
  end

  // Pending settings survive a soft reset; the active copy loads from them at a soft reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pend <= stc_pkg::CFG_DEFAULT;
      srst <= 1'b0;
    end else if (ce_i) begin
      pend <= next_pend;
      srst <= next_srst;
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      active <= srst ? pend : stc_pkg::CFG_DEFAULT;
      delay_val <= stc_pkg::DELAY_RESET;
      rly <= stc_pkg::RELAY_RESET;
      brk <= 2'b00;
      irq_stat <= 4'h0;
      irq_mask <= stc_pkg::IRQ_MASK_RESET;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      active <= next_active;
      delay_val <= next_delay_val;
      rly <= next_rly;
      brk <= next_brk;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o <= next_prdata;
    end
  end

  // ****************************************************************
  // Run lamp, default mode, status lamp, relays, reply delay
  // ****************************************************************
  logic [31:0] diag_cnt;
  logic [31:0] hold_cnt;
  logic [3:0] fault_q;
  logic wd_q;
  logic [15:0] dly_units;
  logic [9:0] dly_tick;
  logic dly_busy;
  logic [3:0] brk_hit;
  stc_pkg::stc_run_t next_run_st;
  logic [31:0] next_diag_cnt;
  logic [31:0] next_hold_cnt;
  logic next_dflt;
  logic next_run_led;
  logic next_status_led;
  logic [3:0] next_relay;
  logic [3:0] next_downscale;
  stc_pkg::stc_cfg_t next_cfg;
  logic next_irq;
  logic [15:0] next_dly_units;
  logic [9:0] next_dly_tick;
  logic next_dly_busy;
  logic next_tx_go;

  // Saturated resistance input counts as a broken lead when breaking downscale
  assign brk_hit = chan_sat_i & {4{brk[stc_pkg::BRK_DOWN_BIT] & brk[stc_pkg::BRK_RES_BIT]}};
  assign fault = chan_fault_i | brk_hit;

  always_comb begin
    next_run_st = run_st;
    next_diag_cnt = (diag_cnt == DIAG_CYCLES) ? diag_cnt : diag_cnt + 32'h0000_0001;
    unique case (run_st)
      stc_pkg::RUN_DIAG: begin
        if (diag_done_i && diag_fail_i) begin
          next_run_st = stc_pkg::RUN_FAIL;
        end else if (diag_done_i && diag_cnt == DIAG_CYCLES) begin
          next_run_st = stc_pkg::RUN_OK;
        end
      end
      stc_pkg::RUN_OK: next_run_st = stc_pkg::RUN_OK;
      stc_pkg::RUN_FAIL: next_run_st = stc_pkg::RUN_FAIL;
      default: next_run_st = stc_pkg::RUN_DIAG;
    endcase
    // Flash while diagnosing or failed, steady when passed
    next_run_led = (next_run_st == stc_pkg::RUN_OK) ? 1'b1 : slow_ph;
    // Default mode after a long press, left only by reset
    next_hold_cnt = btn_s2 ? ((hold_cnt == HOLD_CYCLES) ? hold_cnt
                                                        : hold_cnt + 32'h0000_0001) : 32'h0;
    next_dflt = dflt | (hold_cnt == HOLD_CYCLES);
    next_cfg = next_dflt ? stc_pkg::CFG_DEFAULT : active;
    // Steady fault masks both blink patterns
    if (|fault) begin
      next_status_led = 1'b1;
    end else if (wd_timeout_i) begin
      next_status_led = fast_ph;
    end else if (dflt) begin
      next_status_led = slow_ph;
    end else begin
      next_status_led = 1'b0;
    end
    // Watchdog over alarm over manual
    for (int i = 0; i < 4; i++) begin
      if (rly.wd_en[i] && wd_timeout_i) begin
        next_relay[i] = rly.wd_state[i];
      end else if (rly.alarm_en[i]) begin
        next_relay[i] = alarm_i[i];
      end else begin
        next_relay[i] = rly.manual[i];
      end
    end
    next_downscale = brk_hit | (chan_fault_i & {4{brk[stc_pkg::BRK_DOWN_BIT]}});
    // Events for the interrupt status
    irq_evt = 4'h0;
    irq_evt[stc_pkg::IRQ_DIAG_BIT] = (run_st == stc_pkg::RUN_DIAG) &&
                                     (next_run_st != stc_pkg::RUN_DIAG);
    irq_evt[stc_pkg::IRQ_FAULT_BIT] = |(fault & ~fault_q);
    irq_evt[stc_pkg::IRQ_WD_BIT] = wd_timeout_i & ~wd_q;
    irq_evt[stc_pkg::IRQ_DFLT_BIT] = next_dflt & ~dflt;
    next_irq = |(next_irq_stat & next_irq_mask);
    // Reply delay in ticks after the request frame
    next_tx_go = 1'b0;
    next_dly_busy = dly_busy;
    next_dly_units = dly_units;
    next_dly_tick = dly_tick;
    if (frame_done_i) begin
      next_dly_busy = 1'b1;
      next_dly_units = delay_val;
      next_dly_tick = stc_pkg::DELAY_TICK_CYCLES;
    end else if (dly_busy) begin
      if (dly_units == 16'h0000) begin
        next_dly_busy = 1'b0;
        next_tx_go = 1'b1;
      end else if (dly_tick == 10'h001) begin
        next_dly_tick = stc_pkg::DELAY_TICK_CYCLES;
        next_dly_units = dly_units - 16'h0001;
      end else begin
        next_dly_tick = dly_tick - 10'h001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      run_st <= stc_pkg::RUN_DIAG;
      diag_cnt <= 32'h0000_0000;
      hold_cnt <= 32'h0000_0000;
      dflt <= 1'b0;
      run_led_o <= 1'b0;
      status_led_o <= 1'b0;
      relay_o <= 4'h0;
      downscale_o <= 4'h0;
      comm_cfg_o <= stc_pkg::CFG_DEFAULT;
      irq_o <= 1'b0;
      fault_q <= 4'h0;
      wd_q <= 1'b0;
      dly_units <= 16'h0000;
      dly_tick <= 10'h000;
      dly_busy <= 1'b0;
      tx_go_o <= 1'b0;
    end else if (ce_i) begin
      run_st <= next_run_st;
      diag_cnt <= next_diag_cnt;
      hold_cnt <= next_hold_cnt;
      dflt <= next_dflt;
      run_led_o <= next_run_led;
      status_led_o <= next_status_led;
      relay_o <= next_relay;
      downscale_o <= next_downscale;
      comm_cfg_o <= next_cfg;
      irq_o <= next_irq;
      fault_q <= fault;
      wd_q <= wd_timeout_i;
      dly_units <= next_dly_units;
      dly_tick <= next_dly_tick;
      dly_busy <= next_dly_busy;
      tx_go_o <= next_tx_go;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RUN_STEADY: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && run_st == stc_pkg::RUN_OK |=> run_led_o)
    else $error("run lamp not steady after passing diagnosis");
  AST_RUN_WAIT: assert property (@(posedge clock_i) disable iff (core_rst)
    run_st == stc_pkg::RUN_OK |-> diag_cnt == DIAG_CYCLES)
    else $error("run lamp steady before diagnostic period ended");
  AST_FAIL_STAYS: assert property (@(posedge clock_i) disable iff (core_rst)
    run_st == stc_pkg::RUN_FAIL |=> run_st == stc_pkg::RUN_FAIL)
    else $error("failed diagnosis left the flashing state");
  AST_DFLT_CFG: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && dflt |=> comm_cfg_o == stc_pkg::CFG_DEFAULT)
    else $error("default mode settings not applied");
  AST_FAULT_LAMP: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && |fault |=> status_led_o)
    else $error("status lamp not steady on input fault");
  AST_WD_BLINK: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && !(|fault) && wd_timeout_i |=> status_led_o == $past(fast_ph))
    else $error("watchdog blink pattern wrong");
  AST_DFLT_BLINK: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && !(|fault) && !wd_timeout_i && dflt |=> status_led_o == $past(slow_ph))
    else $error("default mode blink missing");
  AST_SRST_CLEAR: assert property (@(posedge clock_i)
    srst |=> !dflt && relay_o == 4'h0)
    else $error("soft reset did not clear default mode and relays");
  AST_RELAY_PRIO: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && rly.wd_en[0] && wd_timeout_i |=> relay_o[0] == $past(rly.wd_state[0]))
    else $error("watchdog state did not own the relay");
  AST_BRK_DOWN: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && |brk_hit |=> (downscale_o & $past(brk_hit)) == $past(brk_hit))
    else $error("saturated input not driven downscale");
  AST_TX_NODELAY: assert property (@(posedge clock_i) disable iff (core_rst)
    ce_i && frame_done_i && delay_val == 16'h0000 ##1 ce_i && !frame_done_i |=> tx_go_o)
    else $error("zero delay reply not released");
  AST_FAST_BLINK: assert property (@(posedge clock_i) disable iff (core_rst)
    FAST_HALF < SLOW_HALF)
    else $error("watchdog blink not faster");

endmodule

// *** verilog/stc_pkg.sv ***
package stc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint DIAG_TIME_MS = 2000;
  localparam longint HOLD_TIME_MS = 100;
  localparam longint SLOW_HALF_MS = 500;
  localparam longint FAST_HALF_MS = 100;
  localparam longint DELAY_TICK_US = 100;
  localparam int unsigned DIAG_CYCLES = int'(DIAG_TIME_MS * 1000000 / CLK_PERIOD_NS);
  localparam int unsigned HOLD_CYCLES = int'(HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS);
  localparam int unsigned SLOW_HALF_CYCLES = int'(SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS);
  localparam int unsigned FAST_HALF_CYCLES = int'(FAST_HALF_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [9:0] DELAY_TICK_CYCLES = 10'(DELAY_TICK_US * 1000 / CLK_PERIOD_NS);

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PEND = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0c;
  localparam logic [7:0] ADDR_RELAY = 8'h10;
  localparam logic [7:0] ADDR_BRK = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int CTRL_SRST_BIT = 0;
  localparam int BRK_DOWN_BIT = 0;
  localparam int BRK_RES_BIT = 1;
  localparam int IRQ_DIAG_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_WD_BIT = 2;
  localparam int IRQ_DFLT_BIT = 3;
  localparam logic [3:0] BAUD_9600 = 4'h3;
  localparam logic [7:0] DFLT_NODE_ADDR = 8'hf7;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Serial settings: pending, active and effective copies
  typedef struct packed {
    logic [7:0] node_addr;
    logic [1:0] parity;
    logic [3:0] baud;
  } stc_cfg_t;

  localparam stc_cfg_t CFG_DEFAULT = '{node_addr: DFLT_NODE_ADDR, parity: PARITY_NONE,
                                       baud: BAUD_9600};

  // Relay control fields
  typedef struct packed {
    logic [3:0] wd_state;
    logic [3:0] wd_en;
    logic [3:0] alarm_en;
    logic [3:0] manual;
  } stc_relay_t;

  localparam stc_relay_t RELAY_RESET = '0;

  // Run lamp states, Gray along diag -> ok
  typedef enum logic [1:0] {
    RUN_DIAG = 2'b00,
    RUN_OK = 2'b01,
    RUN_FAIL = 2'b11
  } stc_run_t;

endpackage

// *** verilog/stc_blink.sv ***
`timescale 1ns/1ps

// Free-running square wave with a half period of HALF cycles
module stc_blink #(
  parameter int unsigned HALF = 4
) (
  // Clock and control
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Blink phase
  output logic phase_o
);

  localparam int W = $clog2(HALF + 1);
  localparam logic [W-1:0] LAST = W'(HALF - 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_phase;

  // Count and toggle
  always_comb begin
    next_cnt = cnt + W'(1);
    next_phase = phase_o;
    if (cnt == LAST) begin
      next_cnt = '0;
      next_phase = ~phase_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt <= '0;
      phase_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      phase_o <= next_phase;
    end
  end

endmodule

// *** testbench/stc_host_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Network master sending request frames
// ****************************************************************
module stc_host_model (
  // Clock
  input wire logic clock_i,
  // From the block
  input wire logic tx_go_i,
  input wire stc_pkg::stc_cfg_t cfg_i,
  // To the block
  output logic frame_done_o,
  output stc_pkg::stc_cfg_t target_o
);
  initial begin
    frame_done_o = 1'b0;
    target_o = '0;
  end

  // One frame, then cycles until reply permission
  task automatic request(output int lat);
    @(posedge clock_i);
    frame_done_o <= 1'b1;
    target_o <= cfg_i; // Host follows the effective settings
    @(posedge clock_i);
    frame_done_o <= 1'b0;
    lat = 0;
    do begin
      @(posedge clock_i);
      lat++;
    end while (tx_go_i !== 1'b1 && lat < 2000);
  endtask
endmodule

// *** testbench/stc_top_tb.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Bench for the supervisory block
// ****************************************************************
module stc_top_tb;
  localparam logic [13:0] NEW_CFG = {8'h12, 2'h1, 4'h5};
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic diag_done = 1'b0;
  logic diag_fail = 1'b0;
  logic [3:0] chan_fault = 4'h0;
  logic [3:0] chan_sat = 4'h0;
  logic [3:0] alarm = 4'h0;
  logic wd_timeout = 1'b0;
  logic ce = 1'b1;
  logic frame_done;
  logic button = 1'b0;
  logic run_led;
  logic status_led;
  logic [3:0] relay;
  logic [3:0] downscale;
  logic tx_go;
  logic irq;
  stc_pkg::stc_cfg_t cfg;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int lat;
  int t;

  // Clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  stc_top #(.DIAG_CYCLES(20), .HOLD_CYCLES(5), .SLOW_HALF(8), .FAST_HALF(2)) stc_top_inst (
    .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .diag_done_i(diag_done), .diag_fail_i(diag_fail), .chan_fault_i(chan_fault),
    .chan_sat_i(chan_sat), .alarm_i(alarm), .wd_timeout_i(wd_timeout),
    .frame_done_i(frame_done), .default_comm_button_i(button), .run_led_o(run_led),
    .status_led_o(status_led), .relay_o(relay), .downscale_o(downscale),
    .tx_go_o(tx_go), .comm_cfg_o(cfg), .irq_o(irq)
  );

  stc_host_model stc_host_model_inst (
    .clock_i(clock_i), .tx_go_i(tx_go), .cfg_i(cfg),
    .frame_done_o(frame_done), .target_o()
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Count lamp changes, status lamp when sel is high
  task toggles(input logic sel, input int n);
    logic prev;
    prev = sel ? status_led : run_led;
    t = 0;
    repeat (n) begin
      @(posedge clock_i);
      if ((sel ? status_led : run_led) !== prev) t++;
      prev = sel ? status_led : run_led;
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    tick(20);
    reset_i <= 1'b0;
    check("relay reset", relay, 32'h0);
    toggles(1'b0, 24);
    check("run flash", 32'(t >= 2), 32'h1);
    diag_done <= 1'b1;
    tick(30);
    toggles(1'b0, 20);
    check("run toggles", t, 32'h0);
    check("run lit", run_led, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", er, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b0, stc_pkg::ADDR_DELAY, 32'h0);
    check("delay reset", rd, 32'h0);
    // Relay priority and watchdog interrupt
    apb(1'b1, stc_pkg::ADDR_IRQ_MASK, 32'h4);
    alarm <= 4'h3;
    wd_timeout <= 1'b1;
    apb(1'b1, stc_pkg::ADDR_RELAY, 32'h013f);
    tick(3);
    check("relay wd", relay, 32'he);
    check("irq up", irq, 32'h1);
    wd_timeout <= 1'b0;
    tick(3);
    check("relay alarm", relay, 32'hf);
    apb(1'b1, stc_pkg::ADDR_IRQ_MASK, 32'h0);
    tick(2);
    check("irq masked", irq, 32'h0);
    apb(1'b0, stc_pkg::ADDR_IRQ_STAT, 32'h0);
    check("stat wd", rd & 32'h4, 32'h4);
    apb(1'b1, stc_pkg::ADDR_IRQ_STAT, 32'h4);
    apb(1'b1, stc_pkg::ADDR_IRQ_MASK, 32'h4);
    apb(1'b0, stc_pkg::ADDR_IRQ_STAT, 32'h0);
    check("stat clear", rd & 32'h4, 32'h0);
    check("irq clear", irq, 32'h0);
    // Saturated input with downscale break
    apb(1'b1, stc_pkg::ADDR_BRK, 32'h3);
    chan_sat <= 4'h4;
    tick(3);
    check("downscale", downscale, 32'h4);
    check("break lamp", status_led, 32'h1);
    chan_sat <= 4'h0;
    // Reply delay
    stc_host_model_inst.request(lat);
    check("reply n0", lat, 32'h2);
    apb(1'b1, stc_pkg::ADDR_DELAY, 32'h1);
    stc_host_model_inst.request(lat);
    check("reply n1", 32'(lat >= 1000 && lat <= 1005), 32'h1);
    // New settings wait for a reset
    apb(1'b1, stc_pkg::ADDR_PEND, 32'h1215);
    tick(3);
    check("cfg held", cfg, stc_pkg::CFG_DEFAULT);
    apb(1'b1, stc_pkg::ADDR_CTRL, 32'h1);
    tick(3);
    check("cfg applied", cfg, NEW_CFG);
    apb(1'b0, stc_pkg::ADDR_ACTIVE, 32'h0);
    check("active read", rd, 32'h0000_1215);
    check("relay srst", relay, 32'h0);
    // Default mode and status lamp patterns
    button <= 1'b1;
    tick(12);
    button <= 1'b0;
    tick(3);
    check("cfg default", cfg, stc_pkg::CFG_DEFAULT);
    toggles(1'b1, 40);
    check("slow blink", 32'(t >= 3 && t <= 7), 32'h1);
    wd_timeout <= 1'b1;
    tick(4);
    toggles(1'b1, 40);
    check("fast blink", 32'(t >= 14), 32'h1);
    // Clock enable low freezes the lamp
    ce <= 1'b0;
    tick(2);
    toggles(1'b1, 20);
    check("ce freeze", t, 32'h0);
    ce <= 1'b1;
    chan_fault <= 4'h1;
    tick(3);
    toggles(1'b1, 20);
    check("fault steady", t, 32'h0);
    check("fault lamp", status_led, 32'h1);
    chan_fault <= 4'h0;
    wd_timeout <= 1'b0;
    apb(1'b1, stc_pkg::ADDR_CTRL, 32'h1);
    tick(3);
    check("cfg leave", cfg, NEW_CFG);
    toggles(1'b1, 20);
    check("status off", {t[30:0], status_led}, 32'h0);
    // Failing diagnosis
    diag_fail <= 1'b1;
    apb(1'b1, stc_pkg::ADDR_CTRL, 32'h1);
    tick(40);
    toggles(1'b0, 40);
    check("run fail", 32'(t >= 3), 32'h1);
    print_verdict();
  end
endmodule
